// File: hdl/pci_config_id_and_command.v
// Configuration identity and per-function command registers of a two-function bus controller
`timescale 1ns/100ps
// Contract
// - Manufacturer code read-only at 00h, both functions
// - Function 0 product code read-only at 02h
// - Function 1 code chosen by socket type
// - Separate command register per function, resets 0000h
// - Error enables ORed across functions internally
// - Bits 15-11 read zero, writes ignored
// - Bit 10 set blocks function interrupt output
// - Bit 10 reads zero without compat enable
// - Bit 9 fast back-to-back held zero
// - SERR driver on bit 8; address parity needs 8,6
// - Reserved bit 7 reads zero, not stored
// - Bit 6 clear ignores parity errors; else PERR on data parity
// - Data parity errors signalled on SERR, gated
// - Bit 5 snoops palette writes, does not claim
// - Bit 4 held zero, plain memory writes only
// - Bit 3 held zero, no special cycles
// - Mastering only while bit 2 set
// - Memory claiming only while bit 1 set
// - I/O claiming only while bit 0 set
`include "cfg_id_cmd_regs.vh"

module pci_config_id_and_command #(
  parameter [15:0] MANUFACTURER_CODE = 16'h1234, // Arbitrary value
  parameter [15:0] PRODUCT_CODE_F0   = 16'h5670, // Arbitrary value
  parameter [15:0] PRODUCT_CODE_SC   = 16'h5671, // Arbitrary value
  parameter [15:0] PRODUCT_CODE_SD   = 16'h5672, // Arbitrary value
  parameter [15:0] PRODUCT_CODE_MS   = 16'h5673  // Arbitrary value
) (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        clkEnable,
  // Configuration access port
  input  wire        cfgRead,
  input  wire        cfgWrite,
  input  wire        cfgFunction,
  input  wire [7:0]  cfgOffset,
  input  wire [3:0]  cfgByteEnable,
  input  wire [31:0] cfgWriteData,
  output reg  [31:0] cfgReadData,
  output reg         cfgDone,
  // Straps and general control
  input  wire [1:0]  socketType,
  input  wire        busRevCompatOn,
  // Events and requests from the bus engine
  input  wire [1:0]  intRequest,
  input  wire [1:0]  masterRequest,
  input  wire        addrParityError,
  input  wire        dataParityError,
  input  wire        paletteWrite,
  input  wire        specialCycle,
  input  wire [1:0]  memHit,
  input  wire [1:0]  ioHit,
  // Controls to the bus engine
  output wire [1:0]  intOutput,
  output wire [1:0]  initiatorAllow,
  output wire        useWriteInvalidate,
  output wire [1:0]  memClaim,
  output wire [1:0]  ioClaim,
  output wire [1:0]  paletteSnoop,
  output wire        paletteClaim,
  output wire        specialCycleClaim,
  output wire        parityResponseOn,
  output wire        perrAssert,
  output wire        serrDriverOn,
  output wire        serrAssert
);

  // ****************************************
  // Local constants
  // ****************************************
  // Two functions here; the per-function port widths are fixed at two bits, not taken from this count
  localparam integer FUNC_COUNT     = 2;
  localparam [7:0]   IDENT_BYTE     = `OFS_MANUFACTURER_ID;
  localparam [7:0]   CMD_BYTE       = `OFS_BUS_CMD_CTRL;
  localparam [5:0]   DWORD_IDENT    = IDENT_BYTE[7:2];
  localparam [5:0]   DWORD_CMD      = CMD_BYTE[7:2];
  localparam [15:0]  CMD_WR_MASK    = `CMD_WRITE_MASK;
  localparam [15:0]  CMD_RST        = `CMD_RESET_VALUE;
  // A reserved strap code reads back as the smartcard code
  localparam [1:0]   SOCKET_DEFAULT = `SOCKET_SMARTCARD;

  // ****************************************
  // Functions
  // ****************************************
  function [15:0] productCode;
    input       func;
    input [1:0] sock;
    begin
      if (!func) begin
        productCode = PRODUCT_CODE_F0;
      end else begin
        case (sock)
          `SOCKET_SMARTCARD: productCode = PRODUCT_CODE_SC;
          `SOCKET_SDMMC:     productCode = PRODUCT_CODE_SD;
          `SOCKET_MEMSTICK:  productCode = PRODUCT_CODE_MS;
          default:           productCode = PRODUCT_CODE_SC;
        endcase
      end
    end
  endfunction

  // Applies byte enables and the write mask to one command register
  function [15:0] cmdMerge;
    input [15:0] old;
    input [15:0] data;
    input [1:0]  be;
    input        compat;
    reg   [15:0] mask;
    begin
      mask = 16'h0000;
      if (be[0]) begin
        mask[7:0] = CMD_WR_MASK[7:0];
      end
      if (be[1]) begin
        mask[15:8] = CMD_WR_MASK[15:8];
      end
      cmdMerge = (old & ~mask) | (data & mask);
      // Without compat the disable bit is never stored, so it cannot spring back later
      if (!compat) begin
        cmdMerge[`CMD_INTX_DISABLE] = 1'b0;
      end
    end
  endfunction

  // ****************************************
  // Offset decode
  // ****************************************
  // True when a byte offset falls in the given configuration dword
  function dwordIs;
    input [7:0] offset;
    input [5:0] dword;
    begin
      dwordIs = (offset[7:2] == dword);
    end
  endfunction

  wire        identSelected;
  wire        cmdSelected;
  wire [1:0]  cmdWriteFunc;
  wire        done_next;

  assign identSelected = dwordIs(cfgOffset, DWORD_IDENT);
  assign cmdSelected   = dwordIs(cfgOffset, DWORD_CMD);

  // One strobe per function, so software never sees a shared command bit
  assign cmdWriteFunc[0] = cfgWrite & cmdSelected & ~cfgFunction;
  assign cmdWriteFunc[1] = cfgWrite & cmdSelected & cfgFunction;

  // Identity writes complete like any other access and change nothing
  assign done_next = cfgRead | cfgWrite;

  // ****************************************
  // Socket strap
  // ****************************************
  reg  [1:0]  socketType_reg;
  wire [1:0]  socketType_next;

  // Sampled once per clock so a strap change mid-run cannot tear a read
  // A change shows on reads one clock later
  assign socketType_next = clkEnable ? socketType : socketType_reg;

  always @(posedge ref_clk) begin
    if (reset) begin
      socketType_reg <= SOCKET_DEFAULT;
    end else begin
      socketType_reg <= socketType_next;
    end
  end

  // ****************************************
  // Identity codes
  // ****************************************
  wire [15:0] productId [0:1];
  wire [15:0] productSel;

  // Function 0 is fixed; function 1 follows the strap
  assign productId[0] = productCode(1'b0, socketType_reg);
  assign productId[1] = productCode(1'b1, socketType_reg);
  assign productSel   = cfgFunction ? productId[1] : productId[0];

  // ****************************************
  // Command registers
  // ****************************************
  wire [15:0] cmdView [0:1];
  wire [1:0]  ioSpaceOn;
  wire [1:0]  memSpaceOn;
  wire [1:0]  initiatorOn;
  wire [1:0]  paletteSnoopOn;
  wire [1:0]  parityRespOn;
  wire [1:0]  sysErrDrvOn;
  wire [1:0]  intxBlocked;

  genvar f;
  generate
    for (f = 0; f < FUNC_COUNT; f = f + 1) begin : gFunc
      reg  [15:0] cmd_reg;
      reg  [15:0] cmd_next;
      wire [15:0] view;

      always @* begin
        cmd_next = cmd_reg;
        if (cmdWriteFunc[f]) begin
          cmd_next = cmdMerge(cmd_reg, cfgWriteData[15:0], cfgByteEnable[1:0], busRevCompatOn);
        end
        if (!busRevCompatOn) begin
          cmd_next[`CMD_INTX_DISABLE] = 1'b0;
        end
      end

      always @(posedge ref_clk) begin
        if (reset) begin
          cmd_reg <= CMD_RST;
        end else if (clkEnable) begin
          cmd_reg <= cmd_next;
        end
      end

      // Read view rebuilt bit by bit; the compat gate acts at once, not a clock later
      // Fields held at zero
      assign view[15:11]                = 5'h00;
      assign view[`CMD_B2B_GEN_ALLOW]   = 1'b0;
      assign view[`CMD_RSVD7]           = 1'b0;
      assign view[`CMD_WRITE_INV_ALLOW] = 1'b0;
      assign view[`CMD_SPECIAL_CYCLE]   = 1'b0;

      // Writable fields
      assign view[`CMD_INTX_DISABLE]    = cmd_reg[`CMD_INTX_DISABLE] & busRevCompatOn;
      assign view[`CMD_SYS_ERR_DRV_ON]  = cmd_reg[`CMD_SYS_ERR_DRV_ON];
      assign view[`CMD_PARITY_RESP_ON]  = cmd_reg[`CMD_PARITY_RESP_ON];
      assign view[`CMD_PALETTE_SNOOP]   = cmd_reg[`CMD_PALETTE_SNOOP];
      assign view[`CMD_INITIATOR_ALLOW] = cmd_reg[`CMD_INITIATOR_ALLOW];
      assign view[`CMD_MEM_SPACE]       = cmd_reg[`CMD_MEM_SPACE];
      assign view[`CMD_IO_SPACE]        = cmd_reg[`CMD_IO_SPACE];
      assign cmdView[f]                 = view;

      assign ioSpaceOn[f]      = view[`CMD_IO_SPACE];
      assign memSpaceOn[f]     = view[`CMD_MEM_SPACE];
      assign initiatorOn[f]    = view[`CMD_INITIATOR_ALLOW];
      assign paletteSnoopOn[f] = view[`CMD_PALETTE_SNOOP];
      assign parityRespOn[f]   = view[`CMD_PARITY_RESP_ON];
      assign sysErrDrvOn[f]    = view[`CMD_SYS_ERR_DRV_ON];
      assign intxBlocked[f]    = view[`CMD_INTX_DISABLE];
    end
  endgenerate

  // ****************************************
  // Readback select
  // ****************************************
  wire [15:0] cmdSelView;

  // Only the addressed function's copy is returned
  assign cmdSelView = cfgFunction ? cmdView[1] : cmdView[0];

  // ****************************************
  // Interrupt gating
  // ****************************************
  // A blocked function keeps its request inside the engine; only the pin is held off
  assign intOutput = intRequest & ~intxBlocked;

  // ****************************************
  // Initiator and target claims
  // ****************************************
  // Enables gate the engine's own address decode; nothing here decodes addresses
  // Claims are levels; the engine samples them in its own decode phase
  assign initiatorAllow = masterRequest & initiatorOn;
  assign memClaim       = memHit & memSpaceOn;
  assign ioClaim        = ioHit & ioSpaceOn;

  // ****************************************
  // Palette snooping
  // ****************************************
  // A snooping function takes the data but leaves the write to its owner
  assign paletteSnoop = {2{paletteWrite}} & paletteSnoopOn;
  assign paletteClaim = paletteWrite & ~(|paletteSnoopOn);

  // ****************************************
  // Shared error enables
  // ****************************************
  // Software sees one enable per function, but the bus has a single PERR and SERR
  wire serrEnAny;
  wire perrEnAny;
  wire addrErrReport;
  wire dataErrReport;

  assign serrEnAny = |sysErrDrvOn;
  assign perrEnAny = |parityRespOn;

  // Address parity is reported only with both enables set
  // Data parity also surfaces on SERR, under the same two enables
  assign addrErrReport = addrParityError & serrEnAny & perrEnAny;
  assign dataErrReport = dataParityError & serrEnAny & perrEnAny;

  assign parityResponseOn = perrEnAny;
  assign perrAssert       = perrEnAny & dataParityError;
  assign serrDriverOn     = serrEnAny;
  assign serrAssert       = addrErrReport | dataErrReport;

  // ****************************************
  // Fixed controls
  // ****************************************
  // Special cycles are never answered, whatever arrives
  assign specialCycleClaim  = 1'b0 & specialCycle;
  // Plain memory writes only
  assign useWriteInvalidate = 1'b0;

  // ****************************************
  // Read path
  // ****************************************
  reg [31:0] readData_next;

  always @* begin
    readData_next = 32'h00000000;
    if (identSelected) begin
      readData_next = {productSel, MANUFACTURER_CODE};
    end else if (cmdSelected) begin
      readData_next = {16'h0000, cmdSelView};
    end
  end

  // Read data holds until the next read, so a slow host may take it late
  always @(posedge ref_clk) begin
    if (reset) begin
      cfgReadData <= 32'h00000000;
      cfgDone     <= 1'b0;
    end else if (clkEnable) begin
      cfgDone <= done_next;
      if (cfgRead) begin
        cfgReadData <= readData_next;
      end
    end
  end

endmodule // pci_config_id_and_command

// File: hdl/cfg_id_cmd_regs.vh
// Offsets, field positions, reset values and constants of the configuration identity and command registers
`ifndef CFG_ID_CMD_REGS_VH
`define CFG_ID_CMD_REGS_VH

// Configuration byte offsets (dword-aligned access uses bits 7:2)
`define OFS_MANUFACTURER_ID   8'h00
`define OFS_PRODUCT_ID        8'h02
`define OFS_BUS_CMD_CTRL      8'h04
`define OFS_GENERAL_CONTROL   8'h86

// Command register fields
`define CMD_IO_SPACE          0
`define CMD_MEM_SPACE         1
`define CMD_INITIATOR_ALLOW   2
`define CMD_SPECIAL_CYCLE     3
`define CMD_WRITE_INV_ALLOW   4
`define CMD_PALETTE_SNOOP     5
`define CMD_PARITY_RESP_ON    6
`define CMD_RSVD7             7
`define CMD_SYS_ERR_DRV_ON    8
`define CMD_B2B_GEN_ALLOW     9
`define CMD_INTX_DISABLE      10

// Writable bits; 15-11, 9, 7, 4 and 3 are held at zero
`define CMD_WRITE_MASK        16'h0567
`define CMD_RESET_VALUE       16'h0000

// General control field that gates the interrupt-disable bit
`define GENCTL_BUS_REV_COMPAT 7

// Socket type codes for function 1
`define SOCKET_SMARTCARD      2'h0
`define SOCKET_SDMMC          2'h1
`define SOCKET_MEMSTICK       2'h2

`endif

// File: test/cfg_id_cmd_properties.sv
// Checker for the identity and command register block
`timescale 1ns/100ps
// ****
// Port relations
// ****
module cfg_id_cmd_checker (
  input wire        ref_clk,
  input wire        reset,
  input wire        clkEnable,
  input wire        cfgRead,
  input wire        cfgWrite,
  input wire        cfgDone,
  input wire [31:0] cfgReadData,
  input wire        busRevCompatOn,
  input wire [1:0]  intRequest,
  input wire [1:0]  intOutput,
  input wire [1:0]  masterRequest,
  input wire [1:0]  initiatorAllow,
  input wire [1:0]  memHit,
  input wire [1:0]  memClaim,
  input wire [1:0]  ioHit,
  input wire [1:0]  ioClaim,
  input wire        addrParityError,
  input wire        dataParityError,
  input wire        paletteWrite,
  input wire [1:0]  paletteSnoop,
  input wire        paletteClaim,
  input wire        useWriteInvalidate,
  input wire        specialCycleClaim,
  input wire        parityResponseOn,
  input wire        perrAssert,
  input wire        serrDriverOn,
  input wire        serrAssert
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_done; $past(clkEnable) |-> cfgDone == $past(cfgRead || cfgWrite); endproperty
  a_done: assert property (p_done) else $error("completion pulse wrong");
  property p_freeze; !$past(clkEnable) |-> $stable(cfgReadData) && cfgDone == $past(cfgDone); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  property p_int; (intOutput & ~intRequest) == 2'b00; endproperty
  a_int: assert property (p_int) else $error("interrupt without request");
  // A cleared compat bit must wipe the disable on the next edge
  property p_compat; $past(!busRevCompatOn) |-> intOutput == intRequest; endproperty
  a_compat: assert property (p_compat) else $error("interrupt blocked without compat");
  property p_init; (initiatorAllow & ~masterRequest) == 2'b00; endproperty
  a_init: assert property (p_init) else $error("mastering without request");
  property p_claim; ((memClaim & ~memHit) | (ioClaim & ~ioHit)) == 2'b00; endproperty
  a_claim: assert property (p_claim) else $error("claim without hit");
  property p_fixed; !useWriteInvalidate && !specialCycleClaim; endproperty
  a_fixed: assert property (p_fixed) else $error("fixed control active");
  property p_serr; serrAssert == (serrDriverOn && parityResponseOn && (addrParityError || dataParityError));
  endproperty
  a_serr: assert property (p_serr) else $error("system error mismatch");
  property p_perr; perrAssert == (parityResponseOn && dataParityError); endproperty
  a_perr: assert property (p_perr) else $error("parity response mismatch");
  property p_pal; paletteClaim == (paletteWrite && paletteSnoop == 2'b00); endproperty
  a_pal: assert property (p_pal) else $error("palette claim without write");
  c_write: cover property (cfgWrite ##1 cfgDone);
  c_serr: cover property (serrAssert);
  c_compat: cover property ($fell(busRevCompatOn));
endmodule // cfg_id_cmd_checker

bind pci_config_id_and_command cfg_id_cmd_checker u_cfg_id_cmd_checker (.*);

// File: test/host_cfg_model.sv
// Host configuration master model
`timescale 1ns/100ps
// ****
// Single-pulse configuration access
// ****
module host_cfg_model (
  input  wire        ref_clk,
  input  wire        cfgDone,
  input  wire [31:0] cfgReadData,
  output reg         cfgRead,
  output reg         cfgWrite,
  output reg         cfgFunction,
  output reg  [7:0]  cfgOffset,
  output reg  [3:0]  cfgByteEnable,
  output reg  [31:0] cfgWriteData
);
  initial {cfgRead, cfgWrite, cfgFunction, cfgOffset, cfgByteEnable, cfgWriteData} = 47'h0;
  task xfer(input w, input f, input [7:0] off, input [3:0] be, input [31:0] d, output [31:0] q);
    integer n;
    begin
      @(negedge ref_clk);
      {cfgWrite, cfgRead, cfgFunction, cfgOffset, cfgByteEnable, cfgWriteData} = {w, !w, f, off, be, d};
      @(negedge ref_clk);
      cfgWrite = 1'b0;
      cfgRead = 1'b0;
      for (n = 0; n < 4 && cfgDone !== 1'b1; n = n + 1) @(negedge ref_clk);
      q = (cfgDone === 1'b1) ? cfgReadData : 32'hFFFFFFFF;
      // Idle lines must not keep looking valid
      cfgWriteData = ~cfgWriteData;
      cfgOffset = ~cfgOffset;
    end
  endtask
endmodule // host_cfg_model

// File: test/tb.sv
// Testbench for the identity and command register block
`timescale 1ns/100ps
`define CHK(a, b) begin checked = checked + 1; if ((a) !== (b)) begin mismatches = mismatches + 1; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
// ****
// Bench
// ****
module tb;
  localparam [63:0] CODES = 64'h5671567356725671;
  reg ref_clk = 1'b0, reset = 1'b1, busRevCompatOn = 1'b0, clkEnable = 1'b1;
  reg [1:0] socketType = 2'h0;
  reg [11:0] ev = 12'h000;
  reg [31:0] q;
  integer mismatches = 0, checked = 0, cyc = 0, i;
  wire cfgRead, cfgWrite, cfgFunction, cfgDone, useWriteInvalidate, paletteClaim, specialCycleClaim;
  wire parityResponseOn, perrAssert, serrDriverOn, serrAssert;
  wire [7:0] cfgOffset;
  wire [3:0] cfgByteEnable;
  wire [31:0] cfgWriteData, cfgReadData;
  wire [1:0] intOutput, initiatorAllow, memClaim, ioClaim, paletteSnoop;
  host_cfg_model u_host_cfg_model (.*);
  pci_config_id_and_command u_pci_config_id_and_command (.*, .intRequest(ev[11:10]),
    .masterRequest(ev[9:8]), .memHit(ev[7:6]), .ioHit(ev[5:4]), .addrParityError(ev[3]),
    .dataParityError(ev[2]), .paletteWrite(ev[1]), .specialCycle(ev[0]));
  initial forever #4 ref_clk = ~ref_clk;
  task wr(input f, input [7:0] off, input [3:0] be, input [15:0] d);
    u_host_cfg_model.xfer(1'b1, f, off, be, {16'h0000, d}, q);
  endtask
  task rd(input f, input [7:0] off, input [31:0] e);
    begin u_host_cfg_model.xfer(1'b0, f, off, 4'hF, 32'h0, q); `CHK(q, e) end
  endtask
  task end_of_test;
    begin
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // Cycle ceiling well above the fewer than one hundred cycles the tests need
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin mismatches = mismatches + 1; end_of_test; end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk) reset = 1'b0;
    rd(0, 8'h04, 32'h0);
    rd(1, 8'h04, 32'h0);
    rd(0, 8'h00, 32'h56701234);
    for (i = 0; i < 4; i = i + 1) begin
      socketType = i;
      rd(1, 8'h00, {CODES[16*i +: 16], 16'h1234});
    end
    rd(0, 8'h08, 32'h0);
    $display("ids and reset values done");
    wr(0, 8'h04, 4'hF, 16'hFFFF);
    rd(0, 8'h04, 32'h00000167);
    rd(1, 8'h04, 32'h0);
    busRevCompatOn = 1'b1;
    wr(1, 8'h04, 4'h1, 16'hFFFF);
    rd(1, 8'h04, 32'h00000067);
    wr(1, 8'h04, 4'h2, 16'hFFFF);
    rd(1, 8'h04, 32'h00000567);
    wr(0, 8'h00, 4'hF, 16'hFFFF);
    `CHK(q === 32'hFFFFFFFF, 1'b0)
    rd(0, 8'h00, 32'h56701234);
    ev = 12'hFFF;
    #1;
    `CHK(({intOutput, initiatorAllow, memClaim, ioClaim, paletteSnoop, paletteClaim}), 11'h3FE)
    `CHK(({useWriteInvalidate, specialCycleClaim, perrAssert, serrDriverOn, serrAssert}), 5'h07)
    busRevCompatOn = 1'b0;
    @(negedge ref_clk);
    `CHK(intOutput, 2'b11)
    rd(1, 8'h04, 32'h00000167);
    $display("command fields done");
    wr(0, 8'h04, 4'hF, 16'h0100);
    wr(1, 8'h04, 4'hF, 16'h0040);
    ev = 12'h008;
    #1;
    `CHK(({serrDriverOn, parityResponseOn, serrAssert, perrAssert}), 4'hE)
    ev = 12'h004;
    #1;
    `CHK(({serrDriverOn, parityResponseOn, serrAssert, perrAssert}), 4'hF)
    wr(0, 8'h04, 4'hF, 16'h0000);
    wr(1, 8'h04, 4'hF, 16'h0000);
    ev = 12'hFFF;
    #1;
    `CHK(({intOutput, initiatorAllow, memClaim, ioClaim, paletteSnoop, paletteClaim}), 11'h601)
    `CHK(({parityResponseOn, perrAssert, serrDriverOn, serrAssert}), 4'h0)
    $display("error and claim gating done");
    @(negedge ref_clk) clkEnable = 1'b0;
    wr(0, 8'h04, 4'hF, 16'h0001);
    `CHK(q, 32'hFFFFFFFF)
    clkEnable = 1'b1;
    rd(0, 8'h04, 32'h0);
    wr(1, 8'h04, 4'hF, 16'h0007);
    rd(1, 8'h04, 32'h00000007);
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    rd(1, 8'h04, 32'h0);
    $display("freeze and mid-run reset done");
    end_of_test;
  end
endmodule // tb
